// >>> bench/sar_analog_model.sv
// comparator and capacitor array model facing the sequencer
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
    input  wire logic               clk,
    input  wire logic               sw_pos,
    input  wire logic               sw_neg,
    input  wire logic               on_input,
    input  wire logic [15:0]        ref_sel,
    input  wire logic signed [17:0] vin,
    output logic                    comp
);
    logic signed [17:0] held_ff;
    logic               flip_ff;
    // track while both switches closed, hold once they open
    always_ff @(posedge clk)
    begin
        if (sw_pos && sw_neg)
            held_ff <= vin;
    end
    // comparator is meaningless while the arrays face the input, so it wanders
    // plain always: the initial value below writes it as well
    always @(posedge clk)
    begin
        flip_ff <= ~flip_ff;
    end
    assign comp = on_input ? flip_ff : (held_ff >= $signed({2'b00, ref_sel}));
    initial flip_ff = 1'b0;
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic               CLOCK, RESET, CONVERT_START, COMP_OUT, DONE, CONVERTING, POWER_UP;
    logic               SAMPLE_SWITCH_POS, SAMPLE_SWITCH_NEG, ARRAY_TO_INPUT, grounded;
    logic [15:0]        DAC_REF_SEL, RESULT;
    logic signed [17:0] vin;
    int                 mismatches, samples_checked, seed, n, k, i;
    int                 corner [6] = '{0, 32768, 65535, 70000, -5, 1};
    sar_conversion_sequencer dut_u (.CLOCK(CLOCK), .RESET(RESET), .CONVERT_START(CONVERT_START),
        .COMP_OUT(COMP_OUT), .SAMPLE_SWITCH_POS(SAMPLE_SWITCH_POS),
        .SAMPLE_SWITCH_NEG(SAMPLE_SWITCH_NEG), .ARRAY_TO_INPUT(ARRAY_TO_INPUT),
        .DAC_REF_SEL(DAC_REF_SEL), .RESULT(RESULT), .DONE(DONE), .CONVERTING(CONVERTING),
        .POWER_UP(POWER_UP));
    sar_analog_model model_u (.clk(CLOCK), .sw_pos(SAMPLE_SWITCH_POS), .sw_neg(SAMPLE_SWITCH_NEG),
        .on_input(ARRAY_TO_INPUT), .ref_sel(DAC_REF_SEL), .vin(vin), .comp(COMP_OUT));
    initial
    begin
        CLOCK = 1'b0;
        forever #50 CLOCK = ~CLOCK;
    end
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    function logic [15:0] code_of(input int v);
        if (v < 0)
            return sar_seq_pkg::CODE_ZERO;
        if (v > 65535)
            return sar_seq_pkg::CODE_FULL;
        return v[15:0];
    endfunction
    task wrap_up;
        $display("checked %0d, wrong %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task convert(input int v);
        @(posedge CLOCK);
        vin <= 18'(v);
        @(negedge CLOCK);
        check("idle state", {12'h000, SAMPLE_SWITCH_POS, SAMPLE_SWITCH_NEG, ARRAY_TO_INPUT,
            POWER_UP}, 16'h000E);
        @(posedge CLOCK);
        CONVERT_START <= 1'b1;
        // count from the start edge so the opening phase is sampled too
        n = -1;
        k = 0;
        grounded = 1'b0;
        while (DONE !== 1'b1 && n < 40)
        begin
            @(posedge CLOCK);
            n++;
            // late random levels must not disturb the run; low before done
            CONVERT_START <= (n < 14) ? 1'($random(seed)) : 1'b0;
            if (grounded)
                vin <= ~vin;
            @(negedge CLOCK);
            grounded = (ARRAY_TO_INPUT === 1'b0);
            if (SAMPLE_SWITCH_POS === 1'b0 && SAMPLE_SWITCH_NEG === 1'b0 && !grounded)
                k++;
            if (grounded && SAMPLE_SWITCH_POS !== 1'b0)
                k = 99;
            if (n == 2)
            begin
                check("first trial", DAC_REF_SEL, sar_seq_pkg::CODE_MID);
                check("busy level", {14'h0000, CONVERTING, POWER_UP}, 16'h0003);
            end
        end
        check("done latency", 16'(n), 16'(2 + 16 * sar_seq_pkg::SETTLE_CYC));
        check("open before ground", 16'(k), 16'(sar_seq_pkg::OPEN_CYC));
        check("result", RESULT, code_of(v));
        @(negedge CLOCK);
        check("done pulse", {15'h0000, DONE}, 16'h0000);
        $display("test done for input %0d", v);
    endtask
    initial
    begin
        seed = 32'h6e498746;
        mismatches = 0;
        samples_checked = 0;
        vin = 18'h00000;
        CONVERT_START = 1'b0;
        RESET = 1'b1;
        repeat (2) @(posedge CLOCK);
        RESET <= 1'b0;
        for (i = 0; i < 6; i++)
            convert(corner[i]);
        // reset in mid-conversion clears the result and returns to sampling
        @(posedge CLOCK);
        CONVERT_START <= 1'b1;
        repeat (6) @(posedge CLOCK);
        RESET <= 1'b1;
        CONVERT_START <= 1'b0;
        @(negedge CLOCK);
        check("reset result", RESULT, sar_seq_pkg::RESULT_RESET);
        check("reset switches", {11'h000, SAMPLE_SWITCH_POS, SAMPLE_SWITCH_NEG, ARRAY_TO_INPUT,
            CONVERTING, DONE}, 16'h001C);
        repeat (2) @(posedge CLOCK);
        RESET <= 1'b0;
        for (i = 0; i < 8; i++)
            convert(int'($unsigned($random(seed)) % 65536));
        wrap_up();
    end
    // fourteen runs of about 21 cycles; a generous margin
    initial
    begin
        #(2000 * 100);
        mismatches++;
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> rtl/sar_bit_timer.sv
// conversion clock divider for bit trials
`timescale 1ns/100ps
`default_nettype none
module sar_bit_timer #(
    parameter int SETTLE = sar_seq_pkg::SETTLE_CYC
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    output logic      tick
);
    // the counter is eight bits wide, so longer settle counts cannot be served
    if (SETTLE < 1 || SETTLE > 256)
    begin : g_bad_settle
        $error("settle count out of range");
    end

    logic [7:0] cnt_ff;

    // internal conversion clock, no serial clock involved
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_ff <= 8'h00;
        else if (!run || cnt_ff == 8'(SETTLE - 1))
            cnt_ff <= 8'h00;
        else
            cnt_ff <= cnt_ff + 8'h01;
    end

    assign tick = run && (cnt_ff == 8'(SETTLE - 1));
endmodule
`default_nettype wire

// >>> rtl/sar_conversion_sequencer.sv
// successive-approximation conversion sequencer
// Behaviour
// - convert rise after acquisition starts conversion
// - acquisition: sample switches closed, arrays on inputs
// - open sample switches, then arrays to ground
// - sixteen-bit binary search from the top bit
// - after search: acquire, output code, done pulse
// - trials timed by internal conversion clock
// - straight binary output code
// - overrange saturates at all ones
// - underrange saturates at all zeros
// - result belongs to this conversion's sample
// - at most about 526 kSPS at the 10 MHz clock (19-cycle minimum period), powered down between
// - conversion ignores convert input once started
`timescale 1ns/100ps
`default_nettype none
module sar_conversion_sequencer #(
    parameter int BITS   = sar_seq_pkg::RESOLUTION,
    parameter int SETTLE = sar_seq_pkg::SETTLE_CYC
) (
    input  wire logic            CLOCK,
    input  wire logic            RESET,
    input  wire logic            CONVERT_START,
    input  wire logic            COMP_OUT,
    output logic                 SAMPLE_SWITCH_POS,
    output logic                 SAMPLE_SWITCH_NEG,
    output logic                 ARRAY_TO_INPUT,
    output logic [BITS-1:0]      DAC_REF_SEL,
    output logic [BITS-1:0]      RESULT,
    output logic                 DONE,
    output logic                 CONVERTING,
    output logic                 POWER_UP
);
    // settle count kept small so the latency check stays a short delay
    if (BITS != sar_seq_pkg::RESOLUTION || SETTLE < 1 || SETTLE > 16)
    begin : g_bad_param
        $error("unsupported width or settle count");
    end

    localparam int CW       = $clog2(BITS + 1);
    localparam int DONE_LAT = 2 + 16 * SETTLE;

    typedef enum logic [3:0] {
        ST_ACQ   = 4'b0001,
        ST_OPEN  = 4'b0010,
        ST_XFER  = 4'b0100,
        ST_TRIAL = 4'b1000
    } state_t;

    state_t          state_ff;
    logic            cnv_d_ff;
    logic [BITS-1:0] dac_ff;
    logic [BITS-1:0] ptr_ff;
    logic [BITS-1:0] result_ff;
    logic            done_ff;
    logic            tick;
    logic            start;
    logic [CW-1:0]   trials_ff;

    assign start = CONVERT_START && !cnv_d_ff && (state_ff == ST_ACQ);

    sar_bit_timer #(.SETTLE(SETTLE)) u_timer (
        .clk  (CLOCK),
        .rst  (RESET),
        .run  (state_ff == ST_TRIAL),
        .tick (tick)
    );

    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            cnv_d_ff <= 1'b0;
        else
            cnv_d_ff <= CONVERT_START;
    end

    // convert level not looked at outside acquisition
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            state_ff <= ST_ACQ;
        else
        begin
            unique case (state_ff)
                ST_ACQ:   if (start) state_ff <= ST_OPEN;
                ST_OPEN:  state_ff <= ST_XFER;
                ST_XFER:  state_ff <= ST_TRIAL;
                ST_TRIAL: if (tick && ptr_ff[0]) state_ff <= ST_ACQ;
            endcase
        end
    end

    // trial bit set tentatively, kept only when comparator says below input
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            dac_ff <= '0;
            ptr_ff <= '0;
        end
        else if (state_ff == ST_XFER)
        begin
            dac_ff <= sar_seq_pkg::CODE_MID;
            ptr_ff <= sar_seq_pkg::CODE_MID;
        end
        else if (state_ff == ST_TRIAL && tick)
        begin
            dac_ff <= (COMP_OUT ? dac_ff : (dac_ff & ~ptr_ff)) | (ptr_ff >> 1);
            ptr_ff <= ptr_ff >> 1;
        end
        else if (state_ff == ST_ACQ)
        begin
            dac_ff <= '0;
            ptr_ff <= '0;
        end
    end

    // search clamps naturally: all trials kept gives all ones, none kept zero
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
        begin
            result_ff <= sar_seq_pkg::RESULT_RESET;
            done_ff   <= 1'b0;
        end
        else if (state_ff == ST_TRIAL && tick && ptr_ff[0])
        begin
            result_ff <= COMP_OUT ? dac_ff : (dac_ff & ~ptr_ff);
            done_ff   <= 1'b1;
        end
        else
            done_ff <= 1'b0;
    end

    assign SAMPLE_SWITCH_POS = (state_ff == ST_ACQ);
    assign SAMPLE_SWITCH_NEG = (state_ff == ST_ACQ);
    assign ARRAY_TO_INPUT    = (state_ff == ST_ACQ) || (state_ff == ST_OPEN);
    assign DAC_REF_SEL       = dac_ff;
    assign RESULT            = result_ff;
    assign DONE              = done_ff;
    assign CONVERTING        = (state_ff != ST_ACQ);
    assign POWER_UP          = (state_ff != ST_ACQ);

    // trial counter for checking only, drives no output
    always_ff @(posedge CLOCK or posedge RESET)
    begin
        if (RESET)
            trials_ff <= '0;
        else if (state_ff == ST_XFER)
            trials_ff <= '0;
        else if (state_ff == ST_TRIAL && tick)
            trials_ff <= trials_ff + CW'(1);
    end

    property p_start;
        @(posedge CLOCK) disable iff (RESET)
        start |=> (state_ff == ST_OPEN);
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_acq_switches;
        @(posedge CLOCK) disable iff (RESET)
        (state_ff == ST_ACQ) |-> SAMPLE_SWITCH_POS && SAMPLE_SWITCH_NEG && ARRAY_TO_INPUT;
    endproperty
    a_acq_switches: assert property (p_acq_switches) else $error("acq switches wrong");

    property p_order;
        @(posedge CLOCK) disable iff (RESET)
        $fell(SAMPLE_SWITCH_POS) |-> ARRAY_TO_INPUT ##1 !ARRAY_TO_INPUT;
    endproperty
    a_order: assert property (p_order) else $error("switch order wrong");

    property p_length;
        @(posedge CLOCK) disable iff (RESET)
        $rose(CONVERTING) |-> ##DONE_LAT DONE;
    endproperty
    a_length: assert property (p_length) else $error("conversion length wrong");

    property p_done_acq;
        @(posedge CLOCK) disable iff (RESET)
        DONE |-> (state_ff == ST_ACQ) && !CONVERTING;
    endproperty
    a_done_acq: assert property (p_done_acq) else $error("done outside acq");

    property p_msb_first;
        @(posedge CLOCK) disable iff (RESET)
        (state_ff == ST_XFER) |=> (DAC_REF_SEL == sar_seq_pkg::CODE_MID);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb not first");

    property p_full;
        @(posedge CLOCK) disable iff (RESET)
        (state_ff == ST_TRIAL) && tick && ptr_ff[0] && COMP_OUT && (dac_ff == '1)
            |=> (RESULT == sar_seq_pkg::CODE_FULL);
    endproperty
    a_full: assert property (p_full) else $error("overrange not clamped");

    property p_zero;
        @(posedge CLOCK) disable iff (RESET)
        (state_ff == ST_TRIAL) && tick && ptr_ff[0] && !COMP_OUT && (dac_ff == BITS'(1))
            |=> (RESULT == sar_seq_pkg::CODE_ZERO);
    endproperty
    a_zero: assert property (p_zero) else $error("underrange not clamped");

    property p_step;
        @(posedge CLOCK) disable iff (RESET)
        (state_ff == ST_TRIAL) && tick && !ptr_ff[0]
            |=> ((DAC_REF_SEL & $past(ptr_ff)) == ($past(COMP_OUT) ? $past(ptr_ff) : '0))
                && ((DAC_REF_SEL & ptr_ff) == ptr_ff);
    endproperty
    a_step: assert property (p_step) else $error("trial bit not kept or cleared");

    property p_trials;
        @(posedge CLOCK) disable iff (RESET)
        DONE |-> (trials_ff == CW'(BITS));
    endproperty
    a_trials: assert property (p_trials) else $error("trial count wrong");

    // result moves only at the edge that raises done
    property p_hold;
        @(posedge CLOCK) disable iff (RESET)
        $changed(RESULT) |-> $rose(DONE);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved without done");

    property p_no_restart;
        @(posedge CLOCK) disable iff (RESET)
        CONVERTING && !DONE |=> CONVERTING || DONE;
    endproperty
    a_no_restart: assert property (p_no_restart) else $error("conversion aborted");
endmodule
`default_nettype wire

// >>> rtl/sar_seq_pkg.sv
// constants for the successive-approximation sequencer
package sar_seq_pkg;
    localparam int          RESOLUTION     = 16;
    localparam int          CLOCK_FREQ_HZ  = 10_000_000;
    localparam int          MAX_RATE_SPS   = 600_000;
    // shortest conversion period at the top rate, in whole cycles (rounded down)
    localparam int          MIN_PERIOD_CYC = CLOCK_FREQ_HZ / MAX_RATE_SPS;
    localparam int          OPEN_CYC       = 1;
    localparam int          SETTLE_CYC     = 1;
    localparam logic [15:0] CODE_ZERO      = 16'h0000;
    localparam logic [15:0] CODE_MID       = 16'h8000;
    localparam logic [15:0] CODE_FULL      = 16'hFFFF;
    localparam logic [15:0] RESULT_RESET   = 16'h0000;
endpackage
